/* src/fpx_pkg.sv */
/*
 Shared constants for the floating-point status and exception unit:
 status word layout, write mask, exception codes, trap vector and the
 mode-setting instruction encoding.
 Assumes the host decodes floating-point instructions on the same clock.
*/
package fpx_pkg;

   // Status word bit positions
   localparam int ERROR_FLAG_BIT     = 15;
   localparam int INT_DISABLE_BIT    = 14;
   localparam int UNDEF_VAR_EN_BIT   = 11;
   localparam int UNDERFLOW_EN_BIT   = 10;
   localparam int OVERFLOW_EN_BIT    = 9;
   localparam int CONV_ERR_EN_BIT    = 8;
   localparam int DOUBLE_PREC_BIT    = 7;
   localparam int LONG_INT_BIT       = 6;
   localparam int TRUNCATE_BIT       = 5;
   localparam int CC_MSB             = 3;
   localparam int CC_LSB             = 0;
   localparam int CARRY_CC_BIT       = 0;

   // Status word after reset and writable bits (13, 12, 4 unused)
   localparam logic [15:0] PSW_RESET    = 16'h0000;
   localparam logic [15:0] PSW_WR_MASK  = 16'hcfef;

   // Event slots, in priority order, lowest index wins
   localparam int EV_ILLEGAL_OP = 0;
   localparam int EV_DIV_ZERO   = 1;
   localparam int EV_CONV_ERR   = 2;
   localparam int EV_OVERFLOW   = 3;
   localparam int EV_UNDERFLOW  = 4;
   localparam int EV_UNDEF_VAR  = 5;
   localparam int EV_COUNT      = 6;

   // Exception codes (octal 2, 4, 6, 10, 12, 14)
   localparam logic [3:0] CODE_NONE      = 4'h0;
   localparam logic [3:0] CODE_ILLEGAL   = 4'h2;
   localparam logic [3:0] CODE_DIV_ZERO  = 4'h4;
   localparam logic [3:0] CODE_CONV_ERR  = 4'h6;
   localparam logic [3:0] CODE_OVERFLOW  = 4'h8;
   localparam logic [3:0] CODE_UNDERFLOW = 4'ha;
   localparam logic [3:0] CODE_UNDEF_VAR = 4'hc;

   // Trap vector, octal 244
   localparam logic [8:0] TRAP_VECTOR = 9'h0a4;

   // Exponent field limits and highest legal accumulator in mode 0
   localparam logic signed [9:0] EXP_MAX  = 10'sh0ff;
   localparam logic signed [9:0] EXP_MIN  = 10'sh001;
   localparam logic [2:0]        FAC_LAST = 3'h5;

   typedef enum logic [1:0]
   {
      MODE_SET_FLOAT,
      MODE_SET_DOUBLE,
      MODE_SET_INT,
      MODE_SET_LONG
   } fpx_mode_op_type;

   function automatic logic [3:0] event_code(input int idx);
      case (idx)
         EV_ILLEGAL_OP: event_code = CODE_ILLEGAL;
         EV_DIV_ZERO:   event_code = CODE_DIV_ZERO;
         EV_CONV_ERR:   event_code = CODE_CONV_ERR;
         EV_OVERFLOW:   event_code = CODE_OVERFLOW;
         EV_UNDERFLOW:  event_code = CODE_UNDERFLOW;
         EV_UNDEF_VAR:  event_code = CODE_UNDEF_VAR;
         default:       event_code = CODE_NONE;
      endcase
   endfunction

endpackage

/* src/fpx_exc_if.sv */
/*
 Carrier between the status unit and its exception arbiter: raw event
 hits, per-event enables, and the winning exception code.
 Assumes purely combinational use inside one clock domain.
*/
`timescale 1ns/100ps

interface fpx_exc_if;
   logic [5:0] event_hit;
   logic [5:0] event_enable;
   logic       found;
   logic [3:0] code;

   modport unit
   (
      output event_hit,
      output event_enable,
      input  found,
      input  code
   );

   modport arbiter
   (
      input  event_hit,
      input  event_enable,
      output found,
      output code
   );
endinterface

/* src/fpx_trap_arbiter.sv */
/*
 Picks the highest-priority enabled exception of one cycle and gives
 its code.
 Assumes the event slot order of the package is the priority order.
*/
`timescale 1ns/100ps

module fpx_trap_arbiter
(
   fpx_exc_if.arbiter exc
);

   always_comb
   begin
      exc.found = 1'b0;
      exc.code  = fpx_pkg::CODE_NONE;
      for (int i = fpx_pkg::EV_COUNT - 1; i >= 0; i--)
      begin
         if (exc.event_hit[i] && exc.event_enable[i])
         begin
            exc.found = 1'b1;
            exc.code  = fpx_pkg::event_code(i);
         end
      end
   end

endmodule

/* src/fpx_status_unit.sv */
/*
 Program status word and exception reporting of the floating-point
 coprocessor: status word, mode bits, condition codes, exception code,
 result exponent fix-up and the trap request towards the host CPU.
 Assumes the instruction decoder and datapath run on i_sys_clk and
 drive the strobes below for one cycle per instruction step.
*/
`timescale 1ns/100ps

// Functional notes
// RL1: Status and codes reached only by floating-point instruction strobes.
// RL2: Bit 15 error flag sets on every detected error.
// RL3: Bit 14 set blocks every interrupt the unit could raise.
// RL4: Bit 11 set: negative zero fetched from memory raises an interrupt.
// RL5: Bit 11 clear: negative zero moves unchanged, arithmetic sees plus zero.
// RL6: Bit 10 set: underflow traps, exponent off by 400 octal.
// RL7: Bit 10 clear: underflowing result becomes zero, no interrupt.
// RL8: Bit 9 set: overflow traps; result wraps by 400 octal either way.
// RL9: Bit 8 set: store-convert setting carry raises an interrupt.
// RL10: Conversion error clears destination and leaves source untouched.
// RL11: Bit 7 selects double precision when set, single when clear.
// RL12: Bit 6 selects 32-bit integers when set, 16-bit when clear.
// RL13: Bit 5 set truncates results; clear rounds them.
// RL14: Bits 3-0 hold N Z V C; copy op moves them to the CPU.
// RL15: Every floating-point trap goes through vector 244 octal.
// RL16: Exception codes are 2, 4, 6, 10, 12, 14 octal.
// RL17: Erroneous opcode raises exception code 2.
// RL18: Division by zero raises code 4 unless interrupts are disabled.
// RL19: Codes 6, 10, 12, 14 enabled individually; disable bit blocks all.
// RL20: Host keeps exception address register of the faulting instruction.
// RL21: Mode 0 accumulator select of 6 or 7 traps as code 2.
// RL22: Bits 13, 12 and 4 ignore writes and read as zero.
// RL23: Error flag and code are loaded before the trap request rises.
module fpx_status_unit
(
   input  wire logic                     i_sys_clk,
   input  wire logic                     i_srst,
   // Status word load and store instructions
   input  wire logic                     i_psw_load,
   input  wire logic [15:0]              i_psw_wdata,
   output logic      [15:0]              o_psw,
   output logic      [3:0]               o_exception_code,
   // Mode-setting instructions
   input  wire logic                     i_mode_set,
   input  wire fpx_pkg::fpx_mode_op_type i_mode_op,
   // Condition code update and copy to CPU
   input  wire logic                     i_cc_write,
   input  wire logic [3:0]               i_cc_value,
   input  wire logic                     i_copy_cc,
   output logic      [3:0]               o_cpu_cc,
   output logic                          o_cpu_cc_load,
   // Instruction checks
   input  wire logic                     i_instr_valid,
   input  wire logic                     i_bad_opcode,
   input  wire logic                     i_addr_mode0,
   input  wire logic [2:0]               i_fac_select,
   input  wire logic                     i_store_convert,
   input  wire logic                     i_div_zero,
   // Operand fetch
   input  wire logic                     i_operand_valid,
   input  wire logic                     i_operand_from_mem,
   input  wire logic                     i_operand_arith,
   input  wire logic [15:0]              i_operand_high,
   output logic      [15:0]              o_operand_high,
   // Result exponent
   input  wire logic                     i_result_valid,
   input  wire logic signed [9:0]        i_result_exp,
   output logic      [7:0]               o_result_exp,
   output logic                          o_result_zero,
   output logic                          o_result_valid,
   output logic                          o_conv_dest_clear,
   // Mode outputs for the datapath
   output logic                          o_double_precision,
   output logic                          o_long_integer,
   output logic                          o_truncate,
   output logic                          o_neg_zero_as_pos,
   // Trap request towards host
   output logic                          o_trap_req,
   output logic      [8:0]               o_trap_vector,
   input  wire logic                     i_trap_ack
);

   typedef enum logic [1:0]
   {
      TRAP_IDLE,
      TRAP_LATCHED,
      TRAP_WAIT_ACK
   } fpx_trap_state_type;

   fpx_exc_if exc ();

   fpx_trap_state_type trap_state;
   fpx_trap_state_type next_trap_state;

   logic [15:0] psw;
   logic [3:0]  exception_code;
   logic [3:0]  cpu_cc;
   logic        cpu_cc_load;
   logic [7:0]  result_exp;
   logic        result_zero;
   logic        result_valid;
   logic        conv_dest_clear;
   logic [15:0] operand_high;

   logic        error_flag;
   logic        interrupt_disable_all;
   logic        undefined_variable_int_enable;
   logic        underflow_int_enable;
   logic        overflow_int_enable;
   logic        conversion_error_int_enable;

   logic        illegal_fac;
   logic        neg_zero_fetch;
   logic        exp_overflow;
   logic        exp_underflow;
   logic        conv_error;
   logic        any_error;
   logic        trap_ready;

   assign error_flag                    = psw[fpx_pkg::ERROR_FLAG_BIT];
   assign interrupt_disable_all         = psw[fpx_pkg::INT_DISABLE_BIT];
   assign undefined_variable_int_enable = psw[fpx_pkg::UNDEF_VAR_EN_BIT];
   assign underflow_int_enable          = psw[fpx_pkg::UNDERFLOW_EN_BIT];
   assign overflow_int_enable           = psw[fpx_pkg::OVERFLOW_EN_BIT];
   assign conversion_error_int_enable   = psw[fpx_pkg::CONV_ERR_EN_BIT];

   // Negative zero: sign set, exponent field zero
   function automatic logic is_neg_zero(input logic [15:0] high);
      is_neg_zero = high[15] && (high[14:7] == 8'h00);
   endfunction

   // RL21 accumulator range check
   assign illegal_fac = i_instr_valid && i_addr_mode0 &&
                        (i_fac_select > fpx_pkg::FAC_LAST);

   assign neg_zero_fetch = i_operand_valid && i_operand_from_mem &&
                           is_neg_zero(i_operand_high);

   assign exp_overflow  = i_result_valid && (i_result_exp > fpx_pkg::EXP_MAX);
   assign exp_underflow = i_result_valid && (i_result_exp < fpx_pkg::EXP_MIN);

   // RL9 carry set by store-convert marks a conversion error
   assign conv_error = i_store_convert && i_cc_write &&
                       i_cc_value[fpx_pkg::CARRY_CC_BIT];

   // RL17 erroneous opcode or bad accumulator
   assign exc.event_hit[fpx_pkg::EV_ILLEGAL_OP] =
      (i_instr_valid && i_bad_opcode) || illegal_fac;
   // RL18 division by zero
   assign exc.event_hit[fpx_pkg::EV_DIV_ZERO]   = i_instr_valid && i_div_zero;
   assign exc.event_hit[fpx_pkg::EV_CONV_ERR]   = conv_error;
   assign exc.event_hit[fpx_pkg::EV_OVERFLOW]   = exp_overflow;
   assign exc.event_hit[fpx_pkg::EV_UNDERFLOW]  = exp_underflow;
   // RL4 negative zero from memory
   assign exc.event_hit[fpx_pkg::EV_UNDEF_VAR]  = neg_zero_fetch;

   // RL19 per-condition enables
   assign exc.event_enable[fpx_pkg::EV_ILLEGAL_OP] = 1'b1;
   assign exc.event_enable[fpx_pkg::EV_DIV_ZERO]   = 1'b1;
   assign exc.event_enable[fpx_pkg::EV_CONV_ERR]   =
      conversion_error_int_enable;
   assign exc.event_enable[fpx_pkg::EV_OVERFLOW]   = overflow_int_enable;
   assign exc.event_enable[fpx_pkg::EV_UNDERFLOW]  = underflow_int_enable;
   assign exc.event_enable[fpx_pkg::EV_UNDEF_VAR]  =
      undefined_variable_int_enable;

   // RL16 even exception codes
   fpx_trap_arbiter u_arbiter
   (
      .exc (exc)
   );

   // RL3 disable bit blocks the trap; only a free slot takes a new one
   assign trap_ready = exc.found && !interrupt_disable_all &&
                       (trap_state == TRAP_IDLE);

   // RL2 any detected error, trapping or not
   assign any_error = exc.found || conv_error || exp_overflow ||
                      exp_underflow;

   // RL1 status word written only by load-status, mode and condition-code strobes and by detected errors
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         psw <= fpx_pkg::PSW_RESET;
      end
      else
      begin
         if (i_psw_load)
         begin
            // RL22 unused bits stay zero
            psw <= i_psw_wdata & fpx_pkg::PSW_WR_MASK;
         end
         else
         begin
            if (i_mode_set)
            begin
               case (i_mode_op)
                  // RL11 precision select
                  fpx_pkg::MODE_SET_FLOAT:
                     psw[fpx_pkg::DOUBLE_PREC_BIT] <= 1'b0;
                  fpx_pkg::MODE_SET_DOUBLE:
                     psw[fpx_pkg::DOUBLE_PREC_BIT] <= 1'b1;
                  // RL12 integer length select
                  fpx_pkg::MODE_SET_INT:
                     psw[fpx_pkg::LONG_INT_BIT] <= 1'b0;
                  fpx_pkg::MODE_SET_LONG:
                     psw[fpx_pkg::LONG_INT_BIT] <= 1'b1;
                  default:
                     psw[fpx_pkg::LONG_INT_BIT] <= psw[fpx_pkg::LONG_INT_BIT];
               endcase
            end
            // RL14 condition codes from the datapath
            if (i_cc_write)
            begin
               psw[fpx_pkg::CC_MSB:fpx_pkg::CC_LSB] <= i_cc_value;
            end
         end
         // RL2 error set wins over a clearing load
         if (any_error)
         begin
            psw[fpx_pkg::ERROR_FLAG_BIT] <= 1'b1;
         end
      end
   end

   // RL23 code loaded in the cycle a trap is taken, at the same edge as the flag
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         exception_code <= fpx_pkg::CODE_NONE;
      end
      else if (trap_ready)
      begin
         exception_code <= exc.code;
      end
   end

   // RL23 request rises only after flag and code are in place
   always_comb
   begin
      next_trap_state = trap_state;
      case (trap_state)
         TRAP_IDLE:
         begin
            if (trap_ready)
            begin
               next_trap_state = TRAP_LATCHED;
            end
         end
         TRAP_LATCHED:
         begin
            next_trap_state = TRAP_WAIT_ACK;
         end
         TRAP_WAIT_ACK:
         begin
            if (i_trap_ack)
            begin
               next_trap_state = TRAP_IDLE;
            end
         end
         default:
         begin
            next_trap_state = TRAP_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         trap_state <= TRAP_IDLE;
      end
      else
      begin
         trap_state <= next_trap_state;
      end
   end

   // RL14 copy condition codes into the CPU
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         cpu_cc      <= 4'h0;
         cpu_cc_load <= 1'b0;
      end
      else
      begin
         cpu_cc_load <= i_copy_cc;
         if (i_copy_cc)
         begin
            cpu_cc <= psw[fpx_pkg::CC_MSB:fpx_pkg::CC_LSB];
         end
      end
   end

   // Result exponent fix-up
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         result_exp      <= 8'h00;
         result_zero     <= 1'b0;
         result_valid    <= 1'b0;
         conv_dest_clear <= 1'b0;
      end
      else
      begin
         result_valid    <= i_result_valid;
         // RL10 destination cleared, source left alone
         conv_dest_clear <= conv_error;
         if (i_result_valid)
         begin
            if (exp_underflow && !underflow_int_enable)
            begin
               // RL7 flush underflow to zero
               result_exp  <= 8'h00;
               result_zero <= 1'b1;
            end
            else
            begin
               // RL6 low byte differs from true exponent by 400 octal
               // RL8 same wrapped result with or without the enable
               result_exp  <= i_result_exp[7:0];
               result_zero <= 1'b0;
            end
         end
      end
   end

   // Operand passed on, negative zero fixed for arithmetic
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         operand_high <= 16'h0000;
      end
      else if (i_operand_valid)
      begin
         // RL5 only arithmetic use loses the sign
         if (i_operand_arith && !undefined_variable_int_enable &&
             is_neg_zero(i_operand_high))
         begin
            operand_high <= {1'b0, i_operand_high[14:0]};
         end
         else
         begin
            operand_high <= i_operand_high;
         end
      end
   end

   assign o_psw              = psw;
   assign o_exception_code   = exception_code;
   assign o_cpu_cc           = cpu_cc;
   assign o_cpu_cc_load      = cpu_cc_load;
   assign o_result_exp       = result_exp;
   assign o_result_zero      = result_zero;
   assign o_result_valid     = result_valid;
   assign o_conv_dest_clear  = conv_dest_clear;
   assign o_operand_high     = operand_high;
   // RL11 precision to the datapath
   assign o_double_precision = psw[fpx_pkg::DOUBLE_PREC_BIT];
   // RL12 integer length to the converter
   assign o_long_integer     = psw[fpx_pkg::LONG_INT_BIT];
   // RL13 truncate instead of round
   assign o_truncate         = psw[fpx_pkg::TRUNCATE_BIT];
   assign o_neg_zero_as_pos  = !undefined_variable_int_enable;
   assign o_trap_req         = (trap_state == TRAP_WAIT_ACK);
   // RL15 single vector for every trap
   assign o_trap_vector      = fpx_pkg::TRAP_VECTOR;

endmodule

/* verification/fpx_status_properties.sv */
/*
 Checker of the status unit, seeing its ports only.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module fpx_status_properties
(
   input logic              i_sys_clk,
   input logic              i_srst,
   input logic              i_psw_load,
   input logic [15:0]       o_psw,
   input logic [3:0]        o_exception_code,
   input logic              i_copy_cc,
   input logic [3:0]        o_cpu_cc,
   input logic              o_cpu_cc_load,
   input logic              i_result_valid,
   input logic signed [9:0] i_result_exp,
   input logic [7:0]        o_result_exp,
   input logic              o_result_zero,
   input logic              o_double_precision,
   input logic              o_long_integer,
   input logic              o_truncate,
   input logic              o_trap_req,
   input logic [8:0]        o_trap_vector,
   input logic              i_trap_ack
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_srst);

   a_unused_bits_zero: assert property
      (o_psw[13:12] == 2'b00 && !o_psw[4]) else $error("unused bit set");
   a_mode_outputs: assert property
      (o_double_precision == o_psw[7] && o_long_integer == o_psw[6]
       && o_truncate == o_psw[5]) else $error("mode output wrong");
   a_vector_fixed: assert property
      (o_trap_vector == 9'h0a4) else $error("trap vector wrong");
   a_codes_legal: assert property
      ($changed(o_exception_code) |-> o_exception_code inside
       {4'h2, 4'h4, 4'h6, 4'h8, 4'ha, 4'hc}) else $error("bad code");
   a_flag_before_trap: assert property
      ($rose(o_trap_req) |-> $past(o_psw[15]) && o_exception_code != 4'h0)
      else $error("trap without flag and code");
   a_disable_blocks: assert property
      ($rose(o_trap_req) |-> !$past(o_psw[14], 2))
      else $error("trap while disabled");
   a_request_held: assert property
      (o_trap_req |=> o_trap_req == !$past(i_trap_ack))
      else $error("trap request not held to ack");
   a_cc_copied: assert property
      (i_copy_cc |=> o_cpu_cc_load && o_cpu_cc == $past(o_psw[3:0]))
      else $error("condition code copy wrong");
   a_underflow_flush: assert property
      (i_result_valid && i_result_exp < 1 && !o_psw[10] && !i_psw_load
       |=> o_result_zero && o_result_exp == 8'h00)
      else $error("underflow not flushed");
   a_overflow_wrap: assert property
      (i_result_valid && i_result_exp > 255 |=> !o_result_zero
       && o_result_exp == $past(i_result_exp[7:0]))
      else $error("overflow exponent wrong");
endmodule

bind fpx_status_unit fpx_status_properties u_props (.*);

/* verification/fpx_host_model.sv */
/*
 Host CPU side: acks trap requests after a chosen delay and notes
 the vector taken and the faulting instruction address.
 Assumes the unit's clock and synchronous reset.
*/
`timescale 1ns/100ps
module fpx_host_model
(
   input  logic        i_sys_clk,
   input  logic        i_srst,
   input  logic        i_trap_req,
   input  logic [8:0]  i_trap_vector,
   input  logic [15:0] i_instr_addr,
   input  logic [3:0]  i_delay,
   output logic        o_trap_ack,
   output logic [8:0]  o_vector_taken,
   output logic [15:0] o_exception_address_reg
);
   logic [3:0] count;
   logic       req_seen;

   // Single ack pulse after delay
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst || o_trap_ack)
      begin
         o_trap_ack <= 1'b0;
         count      <= 4'h0;
      end
      else if (i_trap_req)
      begin
         o_trap_ack <= count == i_delay;
         count      <= count + 4'h1;
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      req_seen <= i_trap_req && !i_srst;
      if (i_trap_req && !req_seen)
      begin
         o_vector_taken          <= i_trap_vector;
         o_exception_address_reg <= i_instr_addr;
      end
   end
endmodule

/* verification/test_fpx_status_unit.sv */
/*
 Bench of the status unit: drives instruction strobes at the
 falling edge, hosts the CPU model and judges the outputs.
 Assumes the checker is bound to the unit.
*/
`timescale 1ns/100ps
module test_fpx_status_unit;
   logic i_sys_clk = 1'b0;
   logic i_srst = 1'b1;
   logic i_psw_load, i_mode_set, i_cc_write, i_copy_cc, i_instr_valid;
   logic i_bad_opcode, i_addr_mode0, i_div_zero, i_store_convert;
   logic i_operand_valid, i_operand_from_mem, i_operand_arith;
   logic i_result_valid, i_trap_ack, o_cpu_cc_load, o_result_zero;
   logic o_result_valid, o_conv_dest_clear, o_double_precision;
   logic o_long_integer, o_truncate, o_neg_zero_as_pos, o_trap_req;
   logic [2:0] i_fac_select;
   logic [3:0] i_cc_value, o_exception_code, o_cpu_cc, delay;
   logic [7:0] o_result_exp;
   logic [8:0] o_trap_vector, vector_taken;
   logic [15:0] i_psw_wdata, o_psw, i_operand_high, o_operand_high;
   logic [15:0] pc, fea;
   logic signed [9:0] i_result_exp;
   fpx_pkg::fpx_mode_op_type i_mode_op;
   wire [2:0] modes = {o_double_precision, o_long_integer, o_truncate};
   int mismatches = 0;
   int total_checks = 0;

   fpx_status_unit u_dut (.*);
   fpx_host_model u_host
   (
      .i_sys_clk               (i_sys_clk),
      .i_srst                  (i_srst),
      .i_trap_req              (o_trap_req),
      .i_trap_vector           (o_trap_vector),
      .i_instr_addr            (pc),
      .i_delay                 (delay),
      .o_trap_ack              (i_trap_ack),
      .o_vector_taken          (vector_taken),
      .o_exception_address_reg (fea)
   );

   always #50 i_sys_clk = ~i_sys_clk;

   task automatic chk(input string n, input logic [15:0] e, s);
      total_checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic step();
      @(negedge i_sys_clk);
      {i_psw_load, i_mode_set, i_cc_write, i_copy_cc, i_instr_valid,
       i_bad_opcode, i_addr_mode0, i_div_zero, i_store_convert,
       i_operand_valid, i_operand_from_mem, i_operand_arith,
       i_result_valid} = '0;
   endtask

   task automatic load_psw(input logic [15:0] v);
      i_psw_load  = 1'b1;
      i_psw_wdata = v;
      step();
   endtask

   task automatic judge(input logic [3:0] c, input logic t);
      if (t)
         chk("flag and code", {1'b1, c}, {o_psw[15], o_exception_code});
      step();
      chk("trap request", t, o_trap_req);
      for (int k = 0; k < 40 && o_trap_req !== 1'b0; k++)
         step();
   endtask

   task automatic t_reset();
      chk("psw", 16'h0, o_psw);
      chk("code", 16'h0, o_exception_code);
      chk("vector", 16'h00a4, o_trap_vector);
      chk("neg zero as pos", 16'h1, o_neg_zero_as_pos);
      $display("test reset finished");
   endtask

   task automatic t_psw();
      load_psw(16'hffff);
      chk("psw", 16'hcfef, o_psw);
      chk("modes", 16'h7, modes);
      chk("neg zero as pos", 16'h0, o_neg_zero_as_pos);
      load_psw(16'h0000);
      chk("psw", 16'h0, o_psw);
      chk("modes", 16'h0, modes);
      $display("test psw finished");
   endtask

   task automatic t_modes();
      fpx_pkg::fpx_mode_op_type ops[4] = '{fpx_pkg::MODE_SET_DOUBLE,
         fpx_pkg::MODE_SET_LONG, fpx_pkg::MODE_SET_FLOAT,
         fpx_pkg::MODE_SET_INT};
      logic [1:0] want[4] = '{2'b10, 2'b11, 2'b01, 2'b00};
      for (int k = 0; k < 4; k++)
      begin
         i_mode_set = 1'b1;
         i_mode_op  = ops[k];
         @(negedge i_sys_clk);
         chk("mode bits", want[k], o_psw[7:6]);
      end
      step();
      $display("test modes finished");
   endtask

   task automatic t_cc();
      i_cc_write = 1'b1;
      i_cc_value = 4'ha;
      step();
      i_copy_cc = 1'b1;
      step();
      chk("cpu cc", 16'h001a, {o_cpu_cc_load, o_cpu_cc});
      step();
      chk("cpu cc load", 16'h0, o_cpu_cc_load);
      $display("test cc finished");
   endtask

   task automatic t_trap();
      logic [15:0] ps[6] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h4000};
      logic [2:0] fac[6] = '{3'h5, 3'h6, 3'h7, 3'h0, 3'h0, 3'h6};
      logic [3:0] cd[6] = '{4'h0, 4'h2, 4'h2, 4'h2, 4'h4, 4'h0};
      for (int k = 0; k < 6; k++)
      begin
         load_psw(ps[k]);
         delay         = 4'(k);
         pc            = 16'h1000 + 16'(k);
         i_instr_valid = 1'b1;
         i_addr_mode0  = 1'b1;
         i_fac_select  = fac[k];
         i_bad_opcode  = k == 3;
         i_div_zero    = k >= 3;
         step();
         judge(cd[k], cd[k] != 4'h0);
         if (cd[k] != 4'h0)
            chk("host address", pc, fea);
      end
      chk("host vector", 16'h00a4, vector_taken);
      $display("test trap finished");
   endtask

   task automatic t_result();
      logic [15:0] ps[6] = '{16'h0, 16'h0400, 16'h0, 16'h0200, 16'h0, 16'h0};
      logic signed [9:0] ex[6] = '{-10'sd3, -10'sd3, 10'sh105, 10'sh105,
         10'sh0ff, 10'sh001};
      logic [7:0] re[6] = '{8'h00, 8'hfd, 8'h05, 8'h05, 8'hff, 8'h01};
      logic [3:0] cd[6] = '{4'h0, 4'ha, 4'h0, 4'h8, 4'h0, 4'h0};
      for (int k = 0; k < 6; k++)
      begin
         load_psw(ps[k]);
         i_result_valid = 1'b1;
         i_result_exp   = ex[k];
         step();
         chk("result exp", re[k], o_result_exp);
         chk("result zero", k == 0, o_result_zero);
         chk("result valid", 16'h1, o_result_valid);
         chk("error flag", k < 4, o_psw[15]);
         judge(cd[k], cd[k] != 4'h0);
      end
      $display("test result finished");
   endtask

   task automatic t_conv();
      for (int k = 0; k < 2; k++)
      begin
         load_psw({7'h0, k[0], 8'h00});
         i_store_convert = 1'b1;
         i_cc_write      = 1'b1;
         i_cc_value      = 4'h1;
         step();
         chk("dest clear", 16'h1, o_conv_dest_clear);
         chk("flag and carry", 16'h8001, o_psw & 16'h8001);
         judge(4'h6, k[0]);
      end
      $display("test conv finished");
   endtask

   task automatic t_undef();
      logic [15:0] oh[3] = '{16'h8000, 16'h0000, 16'h8000};
      for (int k = 0; k < 3; k++)
      begin
         load_psw(k == 0 ? 16'h0800 : 16'h0000);
         i_operand_valid    = 1'b1;
         i_operand_from_mem = 1'b1;
         i_operand_arith    = k == 1;
         i_operand_high     = 16'h8000;
         step();
         chk("operand high", oh[k], o_operand_high);
         judge(4'hc, k == 0);
      end
      $display("test undef finished");
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial
   begin
      {i_psw_load, i_mode_set, i_cc_write, i_copy_cc, i_instr_valid,
       i_bad_opcode, i_addr_mode0, i_div_zero, i_store_convert,
       i_operand_valid, i_operand_from_mem, i_operand_arith,
       i_result_valid} = '0;
      {i_psw_wdata, i_cc_value, i_fac_select, delay} = '0;
      {i_operand_high, i_result_exp, pc} = '0;
      i_mode_op = fpx_pkg::MODE_SET_FLOAT;
      repeat (4) @(negedge i_sys_clk);
      i_srst = 1'b0;
      t_reset();
      t_psw();
      t_modes();
      t_cc();
      t_trap();
      t_result();
      t_conv();
      t_undef();
      stop_test();
   end

   // Tests need well under 1000 cycles
   initial
   begin
      #400000;
      mismatches++;
      stop_test();
   end
endmodule
